// File: hw/ags_pkg.sv
package ags_pkg;
  // ****************************************
  // Sizes and register map
  // ****************************************
  localparam int NGRP = 3;
  localparam int NCH = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_THR = 8'h14;
  localparam logic [7:0] OFS_FIFO = 8'h20;
  localparam logic [7:0] OFS_RES = 8'h40;
  localparam logic [1:0] GRP_EVT = 2'h0;
  localparam logic [1:0] GRP_1 = 2'h1;
  localparam logic [1:0] GRP_2 = 2'h2;
  localparam logic [9:0] RES_FULL = 10'h3ff;
  localparam logic [9:0] RES_ZERO = 10'h000;
  localparam logic [15:0] SEL_NONE = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MODE_CONV, MODE_CAL, MODE_TEST, MODE_OFF} ags_mode_t;

  typedef struct packed {
    logic g1_evt;
    logic [1:0] evt_src;
    logic [2:0] int_en;
    logic [2:0] cont;
    logic [2:0] freeze;
    ags_mode_t mode;
    logic buffered;
  } ags_ctrl_t;

  localparam ags_ctrl_t CTRL_RST = ags_ctrl_t'(15'h0000);

  typedef struct packed {
    ags_mode_t mode;
    logic [3:0] ch;
  } ags_conv_t;

  localparam ags_conv_t CONV_RST = ags_conv_t'(6'h00);
endpackage : ags_pkg

// File: hw/ags_seq.sv
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Channels of one group are converted lowest number first.
// - Simultaneous starts from idle: the group converted last goes first if among them, then event group, group 1, group 2.
// - A running group without freeze finishes before a new group starts.
// - A running freeze group is suspended and the new group converted.
// - Nonzero write to group 2's select, or group 1's when not event started, starts it; zero write does not.
// - External event pin edge starts event group once its selection is set.
// - Three timer event inputs are selectable as alternative event sources.
// - Group 1 may be event started; group 2 only by software.
// - Each group has its own interrupt output with its own enable.
// - Buffered mode: per-group threshold decides when the interrupt rises.
// - Three DMA requests, one per FIFO, only in buffered mode.
// - Compatibility mode stores each result in a per-channel register.
// - Buffered mode pushes results into one FIFO per group.
// - Each result is a 10-bit code from the core.
// - Above high reference gives full scale, below low gives zero.
// - Channel selections cover sixteen inputs, indices 0 to 15.
// - Four modes: convert, calibrate, self-test, powered down.
// - After a group's last channel its end flag is set.
// - Each group runs single pass or continuously.
module ags_seq #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic EXT_EVT_I,
  input wire logic [2:0] TMR_EVT_I,
  output ags_pkg::ags_conv_t CONV_O,
  output logic CONV_REQ_O,
  input wire logic CONV_DONE_I,
  input wire logic signed [11:0] CORE_CODE_I,
  output logic [2:0] INT_O,
  output logic [2:0] DMA_REQ_O
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

  typedef enum logic {ST_IDLE, ST_WAIT} ags_st_t;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] gofs(input logic [7:0] base, input int g);
    gofs = base + 8'(4 * g);
  endfunction : gofs

  // Lowest set bit wins
  function automatic logic [3:0] low_ch(input logic [15:0] m);
    low_ch = 4'h0;
    for (int i = ags_pkg::NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        low_ch = 4'(i);
      end
    end
  endfunction : low_ch

  function automatic logic [1:0] top_grp(input logic [2:0] a);
    top_grp = a[0] ? ags_pkg::GRP_EVT : (a[1] ? ags_pkg::GRP_1 : ags_pkg::GRP_2);
  endfunction : top_grp

  // Out-of-range core codes saturate
  function automatic logic [9:0] clamp(input logic signed [11:0] c);
    if (c < 12'sh000) begin
      clamp = ags_pkg::RES_ZERO;
    end else if (c > $signed({2'h0, ags_pkg::RES_FULL})) begin
      clamp = ags_pkg::RES_FULL;
    end else begin
      clamp = c[9:0];
    end
  endfunction : clamp

  // ****************************************
  // State
  // ****************************************
  ags_pkg::ags_ctrl_t ctrl, next_ctrl;
  logic [15:0] sel [ags_pkg::NGRP];
  logic [15:0] next_sel [ags_pkg::NGRP];
  logic [15:0] rem [ags_pkg::NGRP];
  logic [15:0] next_rem [ags_pkg::NGRP];
  logic [CW-1:0] thr [ags_pkg::NGRP];
  logic [CW-1:0] next_thr [ags_pkg::NGRP];
  logic [CW-1:0] cnt [ags_pkg::NGRP];
  logic [CW-1:0] next_cnt [ags_pkg::NGRP];
  logic [PW-1:0] wp [ags_pkg::NGRP];
  logic [PW-1:0] next_wp [ags_pkg::NGRP];
  logic [PW-1:0] rp [ags_pkg::NGRP];
  logic [PW-1:0] next_rp [ags_pkg::NGRP];
  logic [13:0] fifo_mem [ags_pkg::NGRP][FIFO_DEPTH];
  logic [9:0] res_reg [ags_pkg::NCH];
  logic [2:0] end_flg, next_end, ovf, next_ovf, active, next_act;
  logic [2:0] next_int, next_dma, trig, pop;
  logic [1:0] cur, next_cur, pre_grp, next_pre_grp, g_pick;
  logic pre_vld, next_pre_vld, push, res_we, evt_edge, busy, next_req;
  ags_st_t st, next_st;
  ags_pkg::ags_conv_t next_conv;
  logic [31:0] next_rdata;
  logic [9:0] code;
  logic ext_s1, ext_s2;
  logic [3:0] src_now, src_prev;

  // Pin is asynchronous; timers share our clock
  assign src_now = {TMR_EVT_I, ext_s2};
  assign code = clamp(CORE_CODE_I);
  assign busy = (st == ST_WAIT) || active[cur];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_ctrl = ctrl;
    next_sel = sel;
    next_thr = thr;
    next_rem = rem;
    next_end = end_flg;
    next_ovf = ovf;
    next_act = active;
    next_cur = cur;
    next_pre_vld = pre_vld;
    next_pre_grp = pre_grp;
    next_st = st;
    next_conv = CONV_O;
    next_req = 1'b0;
    next_rdata = 32'h0;
    push = 1'b0;
    res_we = 1'b0;
    g_pick = cur;
    // Register writes; end and overflow status bits clear on one, active bits are read-only
    if (WR_I) begin
      if (ADDR_I == ags_pkg::OFS_CTRL) begin
        next_ctrl = ags_pkg::ags_ctrl_t'(WDATA_I[14:0]);
      end
      if (ADDR_I == ags_pkg::OFS_STAT) begin
        next_end = end_flg & ~WDATA_I[2:0];
        next_ovf = ovf & ~WDATA_I[8:6];
      end
      for (int g = 0; g < ags_pkg::NGRP; g++) begin
        if (ADDR_I == gofs(ags_pkg::OFS_SEL, g)) begin
          next_sel[g] = WDATA_I[15:0];
        end
        if (ADDR_I == gofs(ags_pkg::OFS_THR, g)) begin
          next_thr[g] = WDATA_I[CW-1:0];
        end
      end
    end
    // Event source select and start conditions
    evt_edge = src_now[ctrl.evt_src] && !src_prev[ctrl.evt_src];
    trig[0] = evt_edge && (sel[0] != ags_pkg::SEL_NONE);
    if (ctrl.g1_evt) begin
      trig[1] = evt_edge && (sel[1] != ags_pkg::SEL_NONE);
    end else begin
      trig[1] = WR_I && (ADDR_I == gofs(ags_pkg::OFS_SEL, 1))
                && (WDATA_I[15:0] != ags_pkg::SEL_NONE);
    end
    trig[2] = WR_I && (ADDR_I == gofs(ags_pkg::OFS_SEL, 2))
              && (WDATA_I[15:0] != ags_pkg::SEL_NONE);
    // Sequencer
    case (st)
      ST_IDLE: begin
        if ((ctrl.mode != ags_pkg::MODE_OFF) && (active != 3'h0)) begin
          if (pre_vld) begin
            g_pick = pre_grp;
            next_pre_vld = 1'b0;
          end else if (active[cur]) begin
            g_pick = cur;
          end else begin
            g_pick = top_grp(active);
          end
          next_cur = g_pick;
          next_conv.ch = low_ch(rem[g_pick]);
          next_conv.mode = ctrl.mode;
          next_req = 1'b1;
          next_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (CONV_DONE_I) begin
          if (ctrl.buffered) begin
            if (cnt[cur] != FULL_CNT) begin
              push = 1'b1;
            end else begin
              next_ovf[cur] = 1'b1;
            end
          end else begin
            res_we = 1'b1;
          end
          next_rem[cur][CONV_O.ch] = 1'b0;
          if (next_rem[cur] == ags_pkg::SEL_NONE) begin
            next_end[cur] = 1'b1;
            if (ctrl.cont[cur] && (sel[cur] != ags_pkg::SEL_NONE)) begin
              next_rem[cur] = sel[cur];
            end else begin
              next_act[cur] = 1'b0;
            end
          end
          next_st = ST_IDLE;
        end
      end
      default: next_st = ST_IDLE;
    endcase
    // Starts override; lowest group index loaded last wins pre-emption
    for (int g = ags_pkg::NGRP - 1; g >= 0; g--) begin
      if (trig[g]) begin
        next_act[g] = 1'b1;
        next_rem[g] = next_sel[g];
        if (busy && (2'(g) != cur) && ctrl.freeze[cur]) begin
          next_pre_vld = 1'b1;
          next_pre_grp = 2'(g);
        end
      end
    end
    // FIFO pointers, interrupts and DMA
    for (int g = 0; g < ags_pkg::NGRP; g++) begin
      pop[g] = RD_I && (ADDR_I == gofs(ags_pkg::OFS_FIFO, g)) && (cnt[g] != '0);
      next_cnt[g] = cnt[g] + CW'(push && (cur == 2'(g))) - CW'(pop[g]);
      next_wp[g] = wp[g] + PW'(push && (cur == 2'(g)));
      next_rp[g] = rp[g] + PW'(pop[g]);
      if (ctrl.buffered) begin
        next_int[g] = ctrl.int_en[g] && (thr[g] != '0) && (next_cnt[g] >= thr[g]);
      end else begin
        next_int[g] = ctrl.int_en[g] && next_end[g];
      end
      next_dma[g] = ctrl.buffered && (next_cnt[g] != '0);
    end
    // Read mux, data valid the cycle after the strobe
    if (RD_I) begin
      if (ADDR_I == ags_pkg::OFS_CTRL) begin
        next_rdata = 32'(ctrl);
      end
      if (ADDR_I == ags_pkg::OFS_STAT) begin
        next_rdata = {23'h0, ovf, active, end_flg};
      end
      for (int g = 0; g < ags_pkg::NGRP; g++) begin
        if (ADDR_I == gofs(ags_pkg::OFS_SEL, g)) begin
          next_rdata = {16'h0, sel[g]};
        end
        if (ADDR_I == gofs(ags_pkg::OFS_THR, g)) begin
          next_rdata = 32'(thr[g]);
        end
        if (pop[g]) begin
          next_rdata = {18'h0, fifo_mem[g][rp[g]]};
        end
      end
      if ((ADDR_I[7:6] == ags_pkg::OFS_RES[7:6]) && (ADDR_I[1:0] == 2'h0)) begin
        next_rdata = {22'h0, res_reg[ADDR_I[5:2]]};
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl <= ags_pkg::CTRL_RST;
      for (int g = 0; g < ags_pkg::NGRP; g++) begin
        sel[g] <= 16'h0000;
        rem[g] <= 16'h0000;
        thr[g] <= '0;
        cnt[g] <= '0;
        wp[g] <= '0;
        rp[g] <= '0;
      end
      end_flg <= 3'h0;
      ovf <= 3'h0;
      active <= 3'h0;
      cur <= 2'h0;
      pre_vld <= 1'b0;
      pre_grp <= 2'h0;
      st <= ST_IDLE;
      src_prev <= 4'h0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      RDATA_O <= 32'h0;
      CONV_O <= ags_pkg::CONV_RST;
      CONV_REQ_O <= 1'b0;
      INT_O <= 3'h0;
      DMA_REQ_O <= 3'h0;
    end else if (CE_I) begin
      ctrl <= next_ctrl;
      sel <= next_sel;
      rem <= next_rem;
      thr <= next_thr;
      cnt <= next_cnt;
      wp <= next_wp;
      rp <= next_rp;
      end_flg <= next_end;
      ovf <= next_ovf;
      active <= next_act;
      cur <= next_cur;
      pre_vld <= next_pre_vld;
      pre_grp <= next_pre_grp;
      st <= next_st;
      src_prev <= src_now;
      ext_s1 <= EXT_EVT_I;
      ext_s2 <= ext_s1;
      RDATA_O <= next_rdata;
      CONV_O <= next_conv;
      CONV_REQ_O <= next_req;
      INT_O <= next_int;
      DMA_REQ_O <= next_dma;
    end
  end

  // FIFO words carry the channel id above the code; no reset, the counts guard them
  always_ff @(posedge CLK_I) begin
    if (CE_I && push) begin
      fifo_mem[cur][wp[cur]] <= {CONV_O.ch, code};
    end
  end

  // Result registers clear on reset so an unconverted channel reads zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < ags_pkg::NCH; i++) begin
        res_reg[i] <= ags_pkg::RES_ZERO;
      end
    end else if (CE_I && res_we) begin
      res_reg[CONV_O.ch] <= code;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] below_mask;
  assign below_mask = (16'h0001 << CONV_O.ch) - 16'h0001;

  sequence s_keep_grp;
    $stable(cur) ##1 ($stable(cur) && CONV_REQ_O);
  endsequence

  property p_lowest;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      CONV_REQ_O |-> rem[cur][CONV_O.ch] && ((rem[cur] & below_mask) == 16'h0000);
  endproperty
  a_lowest: assert property (p_lowest) else $error("channel not lowest");

  property p_grp_prio;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (st == ST_IDLE && !pre_vld && !active[cur] && active[0]
       && ctrl.mode != ags_pkg::MODE_OFF) |=> (CONV_REQ_O && cur == ags_pkg::GRP_EVT);
  endproperty
  a_grp_prio: assert property (p_grp_prio) else $error("event group not first");

  property p_finish;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (st == ST_WAIT && CONV_DONE_I && !pre_vld && !ctrl.freeze[cur]
       && ctrl.mode != ags_pkg::MODE_OFF
       && (rem[cur] & ~(16'h0001 << CONV_O.ch)) != 16'h0000) |=> s_keep_grp;
  endproperty
  a_finish: assert property (p_finish) else $error("running group displaced");

  property p_preempt;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (pre_vld && st == ST_IDLE && ctrl.mode != ags_pkg::MODE_OFF)
      |=> (CONV_REQ_O && cur == $past(pre_grp));
  endproperty
  a_preempt: assert property (p_preempt) else $error("pre-emption not taken");

  property p_zero_wr;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (WR_I && ADDR_I == gofs(ags_pkg::OFS_SEL, 2) && !active[2]
       && WDATA_I[15:0] == ags_pkg::SEL_NONE) |=> !active[2];
  endproperty
  a_zero_wr: assert property (p_zero_wr) else $error("zero write started group");

  property p_start_wr;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (WR_I && ADDR_I == gofs(ags_pkg::OFS_SEL, 2)
       && WDATA_I[15:0] != ags_pkg::SEL_NONE) |=> active[2];
  endproperty
  a_start_wr: assert property (p_start_wr) else $error("write did not start group");

  property p_int_en;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (INT_O & ~$past(ctrl.int_en)) == 3'h0;
  endproperty
  a_int_en: assert property (p_int_en) else $error("masked interrupt raised");

  property p_dma_mode;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (DMA_REQ_O != 3'h0) |-> $past(ctrl.buffered);
  endproperty
  a_dma_mode: assert property (p_dma_mode) else $error("DMA outside buffered mode");

  property p_res_store;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (st == ST_WAIT && CONV_DONE_I && !ctrl.buffered)
      |=> res_reg[$past(CONV_O.ch)] == $past(code);
  endproperty
  a_res_store: assert property (p_res_store) else $error("result not stored");

  property p_clamp_hi;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (st == ST_WAIT && CONV_DONE_I && !ctrl.buffered && CORE_CODE_I > 12'sh3ff)
      |=> res_reg[$past(CONV_O.ch)] == ags_pkg::RES_FULL;
  endproperty
  a_clamp_hi: assert property (p_clamp_hi) else $error("no full-scale clamp");

  property p_end_flag;
    @(posedge CLK_I) disable iff (!RST_N_I || !CE_I)
      (st == ST_WAIT && CONV_DONE_I && rem[cur] == (16'h0001 << CONV_O.ch))
      |=> end_flg[$past(cur)];
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag missing");
endmodule : ags_seq

// File: bench/ags_core_model.sv
`timescale 1ns/1ps
// ****************************************
// Converter core stand-in
// ****************************************
module ags_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [3:0] ch_i,
  input wire logic slow_i,
  output logic done_o,
  output logic signed [11:0] code_o
);
  logic busy;
  logic [2:0] cnt;
  logic [3:0] ch_q;

  // One conversion at a time; idle code toggles so a stale code never looks valid
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    code_o <= ~code_o;
    if (!rst_n_i) begin
      busy <= 1'b0;
      cnt <= 3'h0;
      code_o <= 12'sh000;
    end else if (busy) begin
      if (cnt == 3'h0) begin
        busy <= 1'b0;
        done_o <= 1'b1;
        if (ch_q == 4'hf) begin
          code_o <= 12'sh7ff; // Over range
        end else if (ch_q == 4'he) begin
          code_o <= 12'shf00; // Under range
        end else begin
          code_o <= {2'b00, ch_q, 6'h15};
        end
      end else begin
        cnt <= cnt - 3'h1;
      end
    end else if (req_i) begin
      busy <= 1'b1;
      cnt <= slow_i ? 3'h3 : 3'h0; // Slow answer lets a trigger land mid-conversion
      ch_q <= ch_i;
    end
  end
endmodule : ags_core_model

// File: bench/adc_group_sequencer_tb_top.sv
`timescale 1ns/1ps
module adc_group_sequencer_tb_top;
  logic clk, rst_n, ce, wr_s, rd_s, ext_evt, slow, conv_req, conv_done;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] tmr_evt, int_o, dma_o;
  logic signed [11:0] core_code;
  ags_pkg::ags_conv_t conv;
  ags_pkg::ags_ctrl_t c;
  logic [3:0] q[$];
  logic [1:0] md_last;
  int err_count, tests_run, cyc;

  ags_seq u_dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .EXT_EVT_I(ext_evt), .TMR_EVT_I(tmr_evt),
    .CONV_O(conv), .CONV_REQ_O(conv_req), .CONV_DONE_I(conv_done),
    .CORE_CODE_I(core_code), .INT_O(int_o), .DMA_REQ_O(dma_o));
  ags_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .req_i(conv_req), .ch_i(conv.ch),
    .slow_i(slow), .done_o(conv_done), .code_o(core_code));

  // ****************************************
  // Clock, request log, hang guard
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Log requested channels in order
  always @(posedge clk) begin
    cyc++;
    if (rst_n && conv_req === 1'b1) begin
      q.push_back(conv.ch);
      md_last <= conv.mode;
    end
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Clamped code the core model should yield per channel
  function automatic logic [9:0] exp_code(input logic [3:0] ch);
    if (ch == 4'hf) return ags_pkg::RES_FULL;
    if (ch == 4'he) return ags_pkg::RES_ZERO;
    return {ch, 6'h15};
  endfunction : exp_code

  task automatic wait_end(input int b, input logic clr);
    logic [31:0] d;
    for (int i = 0; i < 300; i++) begin
      rd(ags_pkg::OFS_STAT, d);
      if (d[b]) break;
    end
    chk("end flag", 32'(d[b]), 32'h1);
    if (clr) wr(ags_pkg::OFS_STAT, 32'h1 << b);
  endtask : wait_end

  task automatic wait_q(input int n);
    for (int i = 0; i < 500; i++) begin
      if (q.size() >= n) break;
      @(posedge clk);
    end
  endtask : wait_q

  // Nibble i of e is the i-th requested channel
  task automatic chk_q(input logic [63:0] e, input int n);
    chk("req count", 32'(q.size()), 32'(n));
    for (int i = 0; i < n && i < q.size(); i++) chk("req ch", 32'(q[i]), 32'(e[4*i+:4]));
  endtask : chk_q

  task automatic cfg();
    wr(ags_pkg::OFS_CTRL, 32'(c));
    q.delete();
  endtask : cfg

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_order();
    logic [31:0] d;
    rd(ags_pkg::OFS_CTRL, d);
    chk("ctrl reset", d, 32'h0);
    rd(8'hfc, d);
    chk("unmapped", d, 32'h0);
    rd(ags_pkg::OFS_RES + 8'h0c, d);
    chk("result reset", d, 32'h0);
    c = ags_pkg::CTRL_RST;
    cfg();
    wr(ags_pkg::OFS_SEL + 8'h04, 32'h0);
    wr(ags_pkg::OFS_SEL + 8'h08, 32'h0);
    repeat (10) @(posedge clk);
    chk_q(64'h0, 0);
    wr(ags_pkg::OFS_SEL + 8'h08, 32'h0000c421);
    wait_end(2, 1'b1);
    chk_q(64'hfea50, 5);
    for (int i = 0; i < 16; i++) begin
      if (16'hc421 >> i & 16'h1) begin
        rd(ags_pkg::OFS_RES + 8'(4 * i), d);
        chk("result", d, {22'h0, exp_code(4'(i))});
      end
    end
    chk("dma compat", 32'(dma_o), 32'h0);
  endtask : t_order

  task automatic t_prio();
    c = ags_pkg::CTRL_RST;
    c.g1_evt = 1'b1;
    cfg();
    wr(ags_pkg::OFS_SEL, 32'h2);
    wr(ags_pkg::OFS_SEL + 8'h04, 32'h1);
    repeat (10) @(posedge clk);
    chk_q(64'h0, 0);
    ext_evt <= 1'b1;
    repeat (4) @(posedge clk);
    ext_evt <= 1'b0;
    wait_end(0, 1'b1);
    wait_end(1, 1'b1);
    chk_q(64'h01, 2);
    c.g1_evt = 1'b0;
    for (int s = 1; s < 4; s++) begin
      c.evt_src = 2'(s);
      cfg();
      tmr_evt <= ~(3'h1 << (s - 1));
      @(posedge clk);
      tmr_evt <= 3'h0;
      repeat (10) @(posedge clk);
      chk_q(64'h0, 0);
      tmr_evt <= 3'h1 << (s - 1);
      @(posedge clk);
      tmr_evt <= 3'h0;
      wait_end(0, 1'b1);
      chk_q(64'h1, 1);
    end
  endtask : t_prio

  task automatic t_freeze(input logic fz);
    logic [31:0] d;
    c = ags_pkg::CTRL_RST;
    c.freeze = fz ? 3'h4 : 3'h0;
    cfg();
    slow <= 1'b1;
    wr(ags_pkg::OFS_SEL + 8'h08, 32'hf0);
    wait_q(1);
    wr(ags_pkg::OFS_SEL + 8'h04, 32'h1);
    wait_end(1, 1'b1);
    wait_end(2, 1'b1);
    if (fz) chk_q(64'h76504, 5);
    else chk_q(64'h07654, 5);
    rd(ags_pkg::OFS_RES + 8'h10, d);
    chk("kept result", d, {22'h0, exp_code(4'h4)});
    slow <= 1'b0;
  endtask : t_freeze

  task automatic t_int();
    c = ags_pkg::CTRL_RST;
    c.int_en = 3'h2;
    cfg();
    wr(ags_pkg::OFS_SEL + 8'h08, 32'h1);
    wait_end(2, 1'b0);
    repeat (3) @(posedge clk);
    chk("int masked", 32'(int_o), 32'h0);
    wr(ags_pkg::OFS_SEL + 8'h04, 32'h1);
    wait_end(1, 1'b0);
    repeat (3) @(posedge clk);
    chk("int g1", 32'(int_o), 32'h2);
    wr(ags_pkg::OFS_STAT, 32'h6);
    repeat (3) @(posedge clk);
    chk("int clear", 32'(int_o), 32'h0);
  endtask : t_int

  task automatic t_buf();
    logic [31:0] d;
    c = ags_pkg::CTRL_RST;
    c.buffered = 1'b1;
    c.int_en = 3'h4;
    cfg();
    wr(ags_pkg::OFS_THR + 8'h08, 32'h2);
    wr(ags_pkg::OFS_SEL + 8'h08, 32'h6);
    wait_q(2);
    for (int i = 0; i < 100 && int_o[2] !== 1'b1; i++) @(posedge clk);
    chk("int thr", 32'(int_o), 32'h4);
    chk("dma buf", 32'(dma_o), 32'h4);
    rd(ags_pkg::OFS_FIFO + 8'h08, d);
    chk("fifo", d, {18'h0, 4'h1, exp_code(4'h1)});
    repeat (3) @(posedge clk);
    chk("int below", 32'(int_o), 32'h0);
    rd(ags_pkg::OFS_FIFO + 8'h08, d);
    chk("fifo", d, {18'h0, 4'h2, exp_code(4'h2)});
    repeat (3) @(posedge clk);
    chk("dma empty", 32'(dma_o), 32'h0);
    rd(ags_pkg::OFS_FIFO + 8'h08, d);
    chk("fifo empty", d, 32'h0);
    rd(ags_pkg::OFS_RES + 8'h08, d);
    chk("no result reg", d, 32'h0);
    wr(ags_pkg::OFS_CTRL, 32'h0);
    wr(ags_pkg::OFS_STAT, 32'h1ff);
  endtask : t_buf

  task automatic t_cont();
    int n;
    c = ags_pkg::CTRL_RST;
    c.cont = 3'h4;
    cfg();
    wr(ags_pkg::OFS_SEL + 8'h08, 32'h3);
    wait_q(6);
    wr(ags_pkg::OFS_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    n = q.size();
    for (int i = 0; i < 6; i++) chk("cont ch", 32'(q[i]), 32'(i % 2));
    repeat (20) @(posedge clk);
    chk("cont stop", 32'(q.size()), 32'(n));
    wr(ags_pkg::OFS_STAT, 32'h1ff);
  endtask : t_cont

  // Clock enable low: a write is dropped, state holds, nothing starts
  task automatic t_ce();
    logic [31:0] d;
    c = ags_pkg::CTRL_RST;
    cfg();
    ce <= 1'b0;
    wr(ags_pkg::OFS_SEL + 8'h08, 32'h1);
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    rd(ags_pkg::OFS_SEL + 8'h08, d);
    chk("ce hold sel", d, 32'h3);
    repeat (10) @(posedge clk);
    chk_q(64'h0, 0);
  endtask : t_ce

  // Power-down goes last: a group left pending there is never drained
  task automatic t_mode();
    for (int m = 1; m < 3; m++) begin
      c = ags_pkg::CTRL_RST;
      c.mode = ags_pkg::ags_mode_t'(m);
      cfg();
      wr(ags_pkg::OFS_SEL + 8'h08, 32'h1);
      wait_end(2, 1'b1);
      chk("mode", 32'(md_last), 32'(m));
    end
    c.mode = ags_pkg::MODE_OFF;
    cfg();
    wr(ags_pkg::OFS_SEL + 8'h08, 32'h1);
    repeat (20) @(posedge clk);
    chk_q(64'h0, 0);
  endtask : t_mode

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n, wr_s, rd_s, ext_evt, slow, tmr_evt, addr, wdata} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_order();
    t_prio();
    t_freeze(1'b0);
    t_freeze(1'b1);
    t_int();
    t_buf();
    t_cont();
    t_ce();
    t_mode();
    test_done();
  end
endmodule : adc_group_sequencer_tb_top
